//--- logic/rfm_pkg.sv
/*
 * Constants, types and variant lookup functions for the register file and
 * program memory address map of an 8-bit microcontroller core.
 * Assumes a single CPU core driving one program bus and one register bus.
 */
// Function
// - 32K/48K ROM decode up to 7FFF/BFFF
// - 24K ROM decode up to 5FFF
// - lowest 256 bytes are vectors, still usable
// - fetch after reset starts at 0100
// - program bus has 16-bit address, data
// - register file on separate 8-bit bus
// - no external memory interface at all
// - top 64 addresses doubled into set 1/2
// - upper 32 bytes of set 1 banked
// - each register page spans 256 bytes
// - two, three or four pages per variant
// - page selector at DF, 16 pages architected
// - sets by modes, pages by selector, banks by bank instructions
// - bank and system area register mode only
// - working registers via base plus field
// - 16-byte common working area provided
// - extra pages are general-purpose storage
// - reset selects bank 0
// - set 2 only indirect or indexed
// - selector: 4-bit destination, 4-bit source
// - reset bases point at C0 and C8
package rfm_pkg;
    localparam int PGM_AW = 16;
    localparam int PGM_DW = 16;
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;

    localparam logic [15:0] VEC_TOP     = 16'h00ff;
    localparam logic [15:0] RESET_PC    = 16'h0100;
    localparam logic [15:0] ROM_TOP_24K = 16'h5fff;
    localparam logic [15:0] ROM_TOP_32K = 16'h7fff;
    localparam logic [15:0] ROM_TOP_48K = 16'hbfff;

    localparam logic [7:0] SET_BASE        = 8'hc0;
    localparam logic [7:0] SYS_BASE        = 8'hd0;
    localparam logic [7:0] BANK_BASE       = 8'he0;
    localparam logic [7:0] ADDR_PAGE_SEL   = 8'hdf;
    localparam logic [7:0] ADDR_WBASE_LOW  = 8'hd6;
    localparam logic [7:0] ADDR_WBASE_HIGH = 8'hd7;

    localparam logic [7:0] RST_PAGE_SEL   = 8'h00;
    localparam logic [7:0] RST_WBASE_LOW  = 8'hc0;
    localparam logic [7:0] RST_WBASE_HIGH = 8'hc8;

    localparam int PAGE_BYTES   = 256;
    localparam int MAX_PAGES    = 16;
    localparam int IMPL_PAGES   = 4;
    localparam int PAGE_IDX_W   = 2;
    localparam int COMMON_BYTES = 16;
    localparam int BANK_BYTES   = 32;
    localparam int BANK_AW      = 5;
    localparam int COMMON_AW    = 4;

    localparam int DST_MSB   = 7;
    localparam int DST_LSB   = 4;
    localparam int SRC_MSB   = 3;
    localparam int SRC_LSB   = 0;
    localparam int SLICE_MSB = 7;
    localparam int SLICE_LSB = 3;
    localparam int FIELD_HI  = 3;

    typedef enum logic [1:0] {
        MODE_REG  = 2'b00,
        MODE_WORK = 2'b01,
        MODE_IND  = 2'b11,
        MODE_IDX  = 2'b10
    } rfm_mode_e;

    typedef enum logic [2:0] {
        AREA_PAGE   = 3'b000,
        AREA_COMMON = 3'b001,
        AREA_SYS    = 3'b011,
        AREA_BANK   = 3'b010,
        AREA_NONE   = 3'b110
    } rfm_area_e;

    typedef enum logic [1:0] {
        VAR_24K = 2'b00,
        VAR_32K = 2'b01,
        VAR_48K = 2'b11
    } rfm_variant_e;

    function automatic logic [15:0] romTop(rfm_variant_e v);
        case (v)
            VAR_24K: romTop = ROM_TOP_24K;
            VAR_32K: romTop = ROM_TOP_32K;
            default: romTop = ROM_TOP_48K;
        endcase
    endfunction : romTop

    function automatic logic [3:0] pageCount(rfm_variant_e v);
        case (v)
            VAR_24K: pageCount = 4'h2;
            VAR_32K: pageCount = 4'h3;
            default: pageCount = 4'h4;
        endcase
    endfunction : pageCount
endpackage : rfm_pkg

//--- logic/rfm_dec_if.sv
/*
 * Carrier for the decoded register-bus address between the top of the
 * address map and its working-register mapper.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/100ps
interface rfm_dec_if;
    logic                 [7:0] rawAddr;
    rfm_pkg::rfm_mode_e         mode;
    logic                 [7:0] workingBaseLow;
    logic                 [7:0] workingBaseHigh;
    logic                 [7:0] effAddr;
    rfm_pkg::rfm_area_e         area;
    logic                       setTwo;

    modport mapper (
        input  rawAddr, mode, workingBaseLow, workingBaseHigh,
        output effAddr, area, setTwo
    );
    modport user (
        output rawAddr, mode, workingBaseLow, workingBaseHigh,
        input  effAddr, area, setTwo
    );
endinterface : rfm_dec_if

//--- logic/rfm_work_map.sv
/*
 * Forms the effective register address and picks the storage area from
 * the addressing mode. Purely combinational.
 * Assumes the caller holds the working base pointers.
 */
`timescale 1ns/100ps
module rfm_work_map (
    // Decode carrier
    rfm_dec_if.mapper dec
);
    logic [7:0] base;

    always_comb begin
        base = dec.rawAddr[rfm_pkg::FIELD_HI] ? dec.workingBaseHigh : dec.workingBaseLow;
        if (dec.mode == rfm_pkg::MODE_WORK) begin
            dec.effAddr = {base[rfm_pkg::SLICE_MSB:rfm_pkg::SLICE_LSB],
                           dec.rawAddr[rfm_pkg::SLICE_LSB-1:0]};
        end else begin
            dec.effAddr = dec.rawAddr;
        end
    end

    always_comb begin
        dec.setTwo = 1'b0;
        dec.area   = rfm_pkg::AREA_PAGE;
        if (dec.effAddr < rfm_pkg::SET_BASE) begin
            dec.area = rfm_pkg::AREA_PAGE;
        end else if (dec.mode == rfm_pkg::MODE_IND || dec.mode == rfm_pkg::MODE_IDX) begin
            dec.setTwo = 1'b1;
            dec.area   = rfm_pkg::AREA_PAGE;
        end else if (dec.effAddr < rfm_pkg::SYS_BASE) begin
            dec.area = (dec.mode == rfm_pkg::MODE_WORK) ? rfm_pkg::AREA_COMMON
                                                        : rfm_pkg::AREA_NONE;
        end else if (dec.mode != rfm_pkg::MODE_REG) begin
            dec.area = rfm_pkg::AREA_NONE;
        end else if (dec.effAddr < rfm_pkg::BANK_BASE) begin
            dec.area = rfm_pkg::AREA_SYS;
        end else begin
            dec.area = rfm_pkg::AREA_BANK;
        end
    end
endmodule : rfm_work_map

//--- logic/rfm_prog_decode.sv
/*
 * Program memory decode: range check against the fitted ROM size and
 * marking of the vector area. Results are registered.
 * Assumes the ROM array itself answers the same address.
 */
`timescale 1ns/100ps
module rfm_prog_decode #(
    parameter rfm_pkg::rfm_variant_e VARIANT = rfm_pkg::VAR_48K
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Fetch request
    input  wire logic [15:0] pgmAddr,
    input  wire logic        pgmFetch,
    // Decode result
    output logic             pgmHit,
    output logic             pgmFault,
    output logic             pgmVector
);
    logic inRom;

    assign inRom = pgmAddr <= rfm_pkg::romTop(VARIANT);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pgmHit    <= 1'b0;
            pgmFault  <= 1'b0;
            pgmVector <= 1'b0;
        end else begin
            pgmHit   <= pgmFetch && inRom;
            pgmFault <= pgmFetch && !inRom;
            pgmVector <= pgmFetch && (pgmAddr <= rfm_pkg::VEC_TOP);
        end
    end
endmodule : rfm_prog_decode

//--- logic/rfm_addr_map.sv
/*
 * Address map of the core: program memory decode and the paged, banked
 * internal register file with its page selector and working bases.
 * Assumes one CPU core on a 16-bit program bus and an 8-bit register
 * bus, with all ports synchronous to mclk.
 */
`timescale 1ns/100ps
module rfm_addr_map #(
    parameter rfm_pkg::rfm_variant_e VARIANT = rfm_pkg::VAR_48K
) (
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                rst_n,
    // Program bus
    input  wire logic [15:0]         pgmAddr,
    input  wire logic                pgmFetch,
    output logic                     pgmHit,
    output logic                     pgmFault,
    output logic                     pgmVector,
    output logic [15:0]              startPc,
    output logic                     pcLoad,
    // Register bus
    input  wire logic [7:0]          regAddr,
    input  wire rfm_pkg::rfm_mode_e  regMode,
    input  wire logic                regRd,
    input  wire logic                regWr,
    input  wire logic [7:0]          regWrData,
    output logic [7:0]               regRdData,
    output logic                     regRefused,
    // Bank instructions
    input  wire logic                selectLowerBankInstr,
    input  wire logic                selectUpperBankInstr,
    // Status
    output logic                     bankSel,
    output logic [3:0]               dstPage,
    output logic [3:0]               srcPage,
    output logic                     pageCodeBad
);
    localparam logic [3:0] PAGES = rfm_pkg::pageCount(VARIANT);

    // Storage
    logic [7:0] pageMem [rfm_pkg::IMPL_PAGES*rfm_pkg::PAGE_BYTES];
    logic [7:0] commonMem [rfm_pkg::COMMON_BYTES];
    logic [7:0] bankMem [2*rfm_pkg::BANK_BYTES];

    // Control state
    logic [7:0] registerPageSelector;
    logic [7:0] workingBaseLow;
    logic [7:0] workingBaseHigh;
    logic       bank;

    // Decode
    rfm_dec_if dec ();
    logic [7:0]  effAddr;
    logic [3:0]  rdPage;
    logic [3:0]  wrPage;
    logic        rdPageOk;
    logic        wrPageOk;
    logic        sysHit;
    logic        accessOk;
    logic [9:0]  rdIdx;
    logic [9:0]  wrIdx;
    logic [5:0]  bankIdx;
    logic [3:0]  commonIdx;
    logic [7:0]  next_rdData;

    assign dec.rawAddr         = regAddr;
    assign dec.mode            = regMode;
    assign dec.workingBaseLow  = workingBaseLow;
    assign dec.workingBaseHigh = workingBaseHigh;
    assign effAddr             = dec.effAddr;

    rfm_work_map u_work_map (
        .dec (dec.mapper)
    );

    rfm_prog_decode #(
        .VARIANT (VARIANT)
    ) u_prog_decode (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .pgmAddr   (pgmAddr),
        .pgmFetch  (pgmFetch),
        .pgmHit    (pgmHit),
        .pgmFault  (pgmFault),
        .pgmVector (pgmVector)
    );

    assign startPc = rfm_pkg::RESET_PC;

    // Load stays high through reset and one edge after it, so the core
    // sees it whatever its own reset latency.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pcLoad <= 1'b1;
        end else begin
            pcLoad <= 1'b0;
        end
    end

    assign dstPage = registerPageSelector[rfm_pkg::DST_MSB:rfm_pkg::DST_LSB];
    assign srcPage = registerPageSelector[rfm_pkg::SRC_MSB:rfm_pkg::SRC_LSB];

    assign wrPageOk    = dstPage < PAGES;
    assign rdPageOk    = srcPage < PAGES;
    assign pageCodeBad = !wrPageOk || !rdPageOk;

    assign wrPage = dstPage;
    assign rdPage = srcPage;

    assign wrIdx = {wrPage[rfm_pkg::PAGE_IDX_W-1:0], effAddr};
    assign rdIdx = {rdPage[rfm_pkg::PAGE_IDX_W-1:0], effAddr};

    assign bankIdx   = {bank, effAddr[rfm_pkg::BANK_AW-1:0]};
    assign commonIdx = effAddr[rfm_pkg::COMMON_AW-1:0];

    assign sysHit   = dec.area == rfm_pkg::AREA_SYS;
    assign accessOk = dec.area != rfm_pkg::AREA_NONE;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bank <= 1'b0;
        end else if (selectLowerBankInstr) begin
            bank <= 1'b0;
        end else if (selectUpperBankInstr) begin
            bank <= 1'b1;
        end
    end
    assign bankSel = bank;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            registerPageSelector <= rfm_pkg::RST_PAGE_SEL;
        end else if (regWr && sysHit && effAddr == rfm_pkg::ADDR_PAGE_SEL) begin
            registerPageSelector <= regWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            workingBaseLow  <= rfm_pkg::RST_WBASE_LOW;
            workingBaseHigh <= rfm_pkg::RST_WBASE_HIGH;
        end else if (regWr && sysHit) begin
            if (effAddr == rfm_pkg::ADDR_WBASE_LOW) begin
                workingBaseLow <= regWrData;
            end else if (effAddr == rfm_pkg::ADDR_WBASE_HIGH) begin
                workingBaseHigh <= regWrData;
            end
        end
    end

    // area steering
    // Page memory holds the prime area and set 2; set 1 lives in the
    // common and bank arrays and the system registers, so the same C0-FF addresses never collide.
    always_ff @(posedge mclk) begin
        if (regWr && dec.area == rfm_pkg::AREA_PAGE && wrPageOk) begin
            pageMem[wrIdx] <= regWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (regWr && dec.area == rfm_pkg::AREA_COMMON) begin
            commonMem[commonIdx] <= regWrData;
        end
    end

    always_ff @(posedge mclk) begin
        if (regWr && dec.area == rfm_pkg::AREA_BANK) begin
            bankMem[bankIdx] <= regWrData;
        end
    end

    always_comb begin
        next_rdData = '0;
        case (dec.area)
            rfm_pkg::AREA_PAGE: begin
                next_rdData = rdPageOk ? pageMem[rdIdx] : '0;
            end
            rfm_pkg::AREA_COMMON: begin
                next_rdData = commonMem[commonIdx];
            end
            rfm_pkg::AREA_BANK: begin
                next_rdData = bankMem[bankIdx];
            end
            rfm_pkg::AREA_SYS: begin
                // Other system slots belong to peripherals outside
                if (effAddr == rfm_pkg::ADDR_PAGE_SEL) begin
                    next_rdData = registerPageSelector;
                end else if (effAddr == rfm_pkg::ADDR_WBASE_LOW) begin
                    next_rdData = workingBaseLow;
                end else if (effAddr == rfm_pkg::ADDR_WBASE_HIGH) begin
                    next_rdData = workingBaseHigh;
                end else begin
                    next_rdData = '0;
                end
            end
            default: begin
                next_rdData = '0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            regRdData <= '0;
        end else if (regRd) begin
            regRdData <= next_rdData;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            regRefused <= 1'b0;
        end else begin
            regRefused <= (regRd || regWr) && !accessOk;
        end
    end
endmodule : rfm_addr_map

//--- test/rfm_addr_map_asserts.sv
/* Port-level assertions for the register file and program memory map.
   Assumes binding to rfm_addr_map, all ports synchronous to mclk. */
`timescale 1ns/100ps
module rfm_addr_map_asserts #(
    parameter rfm_pkg::rfm_variant_e VARIANT = rfm_pkg::VAR_48K
) (
    // Clock and reset
    input wire logic               mclk,
    input wire logic               rst_n,
    // Program bus
    input wire logic [15:0]        pgmAddr,
    input wire logic               pgmFetch,
    input wire logic               pgmHit,
    input wire logic               pgmFault,
    input wire logic               pgmVector,
    input wire logic [15:0]        startPc,
    input wire logic               pcLoad,
    // Register bus
    input wire logic [7:0]         regAddr,
    input wire rfm_pkg::rfm_mode_e regMode,
    input wire logic               regRd,
    input wire logic               regWr,
    input wire logic [7:0]         regWrData,
    input wire logic [7:0]         regRdData,
    input wire logic               regRefused,
    // Banks and pages
    input wire logic               selectLowerBankInstr,
    input wire logic               selectUpperBankInstr,
    input wire logic               bankSel,
    input wire logic [3:0]         dstPage,
    input wire logic [3:0]         srcPage,
    input wire logic               pageCodeBad
);
    localparam logic [15:0] TOP = (VARIANT == rfm_pkg::VAR_24K) ? 16'h5fff :
        (VARIANT == rfm_pkg::VAR_32K) ? 16'h7fff : 16'hbfff;
    localparam logic [3:0] CNT = (VARIANT == rfm_pkg::VAR_24K) ? 4'h2 :
        (VARIANT == rfm_pkg::VAR_32K) ? 4'h3 : 4'h4;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    start_pc_a: assert property (startPc == 16'h0100)
        else $error("start address wrong");
    pc_load_a: assert property ($rose(rst_n) |-> pcLoad ##1 !pcLoad)
        else $error("pc load not one edge after reset");
    rom_hit_a: assert property (pgmFetch && pgmAddr <= TOP |=> pgmHit && !pgmFault)
        else $error("fetch inside rom not a hit");
    rom_fault_a: assert property (pgmFetch && pgmAddr > TOP |=> pgmFault && !pgmHit)
        else $error("fetch above rom not a fault");
    vector_area_a: assert property (pgmFetch |=> pgmVector == ($past(pgmAddr) <= 16'h00ff))
        else $error("vector flag wrong");
    fetch_idle_a: assert property (!pgmFetch |=> !pgmHit && !pgmFault)
        else $error("decode answer without fetch");
    common_refuse_a: assert property (regRd && regMode == rfm_pkg::MODE_REG
        && regAddr[7:4] == 4'hc |=> regRefused && regRdData == 8'h00)
        else $error("common area open to register mode");
    set_two_a: assert property ((regRd || regWr) && (regMode == rfm_pkg::MODE_IND
        || regMode == rfm_pkg::MODE_IDX) |=> !regRefused)
        else $error("indirect access refused");
    bank_lower_a: assert property (selectLowerBankInstr |=> !bankSel)
        else $error("lower bank not selected");
    bank_upper_a: assert property (selectUpperBankInstr && !selectLowerBankInstr |=> bankSel)
        else $error("upper bank not selected");
    page_write_a: assert property (regWr && regMode == rfm_pkg::MODE_REG && regAddr == 8'hdf
        |=> {dstPage, srcPage} == $past(regWrData))
        else $error("page selector not written");
    page_bad_a: assert property (pageCodeBad == (dstPage >= CNT || srcPage >= CNT))
        else $error("page code check wrong");
endmodule : rfm_addr_map_asserts

//--- test/rfm_cpu_model.sv
/* Behavioural CPU core: drives the program and register buses.
   Assumes mclk from the bench; requests change on the falling edge. */
`timescale 1ns/100ps
module rfm_cpu_model (
    // Clock
    input wire logic               mclk,
    // Program bus
    output logic [15:0]            pgmAddr,
    output logic                   pgmFetch,
    input wire logic               pgmHit,
    input wire logic               pgmFault,
    input wire logic               pgmVector,
    // Register bus
    output logic [7:0]             regAddr,
    output rfm_pkg::rfm_mode_e     regMode,
    output logic                   regRd,
    output logic                   regWr,
    output logic [7:0]             regWrData,
    input wire logic [7:0]         regRdData,
    input wire logic               regRefused,
    // Bank instructions
    output logic                   selectLowerBankInstr,
    output logic                   selectUpperBankInstr
);
    initial begin
        {pgmAddr, pgmFetch, regAddr, regRd, regWr, regWrData} = '0;
        regMode = rfm_pkg::MODE_REG;
        {selectLowerBankInstr, selectUpperBankInstr} = '0;
    end

    task automatic regOp(input logic wr, input rfm_pkg::rfm_mode_e m, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q, output logic rf);
        @(negedge mclk);
        regAddr <= a;
        regMode <= m;
        regWrData <= d;
        regWr <= wr;
        regRd <= !wr;
        @(negedge mclk);
        q = regRdData;
        rf = regRefused;
        regRd <= 1'b0;
        regWr <= 1'b0;
        // Released lines show junk, not the last value
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : regOp

    task automatic fetch(input logic [15:0] a, output logic h, output logic f, output logic v);
        @(negedge mclk);
        pgmAddr <= a;
        pgmFetch <= 1'b1;
        @(negedge mclk);
        {h, f, v} = {pgmHit, pgmFault, pgmVector};
        pgmFetch <= 1'b0;
        pgmAddr <= ~a;
    endtask : fetch

    task automatic bank(input logic upper);
        @(negedge mclk);
        selectUpperBankInstr <= upper;
        selectLowerBankInstr <= !upper;
        @(negedge mclk);
        {selectLowerBankInstr, selectUpperBankInstr} <= 2'b00;
    endtask : bank
endmodule : rfm_cpu_model

//--- test/tb_top.sv
/* Self-checking bench for the address map, 32 KB variant (three pages).
   Assumes the CPU model drives every design input except mclk and rst_n. */
`timescale 1ns/100ps
module tb_top;
    logic               mclk, rst_n, pgmFetch, pgmHit, pgmFault, pgmVector, pcLoad;
    logic [15:0]        pgmAddr, startPc;
    logic [7:0]         regAddr, regWrData, regRdData, q;
    rfm_pkg::rfm_mode_e regMode;
    logic               regRd, regWr, regRefused, lowB, upB, bankSel, pageCodeBad, rf;
    logic [3:0]         dstPage, srcPage;
    logic               h, f, v;
    logic [15:0]        fa [6] = '{16'h0000, 16'h00ff, 16'h0100, 16'h7fff, 16'h8000, 16'hffff};
    int                 mismatches = 0;
    int                 total_checks = 0;
    int                 cycles = 0;

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    rfm_addr_map #(.VARIANT(rfm_pkg::VAR_32K)) u_dut (.mclk(mclk), .rst_n(rst_n),
        .pgmAddr(pgmAddr), .pgmFetch(pgmFetch), .pgmHit(pgmHit), .pgmFault(pgmFault),
        .pgmVector(pgmVector), .startPc(startPc), .pcLoad(pcLoad), .regAddr(regAddr),
        .regMode(regMode), .regRd(regRd), .regWr(regWr), .regWrData(regWrData),
        .regRdData(regRdData), .regRefused(regRefused), .selectLowerBankInstr(lowB),
        .selectUpperBankInstr(upB), .bankSel(bankSel), .dstPage(dstPage),
        .srcPage(srcPage), .pageCodeBad(pageCodeBad));

    rfm_cpu_model u_cpu (.mclk(mclk), .pgmAddr(pgmAddr), .pgmFetch(pgmFetch),
        .pgmHit(pgmHit), .pgmFault(pgmFault), .pgmVector(pgmVector), .regAddr(regAddr),
        .regMode(regMode), .regRd(regRd), .regWr(regWr), .regWrData(regWrData),
        .regRdData(regRdData), .regRefused(regRefused), .selectLowerBankInstr(lowB),
        .selectUpperBankInstr(upB));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input rfm_pkg::rfm_mode_e m, input logic [7:0] a, input logic [7:0] d);
        u_cpu.regOp(1'b1, m, a, d, q, rf);
    endtask : wr

    task automatic rd(input rfm_pkg::rfm_mode_e m, input logic [7:0] a, input logic [7:0] d,
        input logic r);
        u_cpu.regOp(1'b0, m, a, 8'h00, q, rf);
        check("regRdData", {8'h00, q}, {8'h00, d});
        check("regRefused", {15'h0, rf}, {15'h0, r});
    endtask : rd

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // Whole run needs about 95 cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        rst_n = 1'b0;
        repeat (5) @(negedge mclk);
        check("pcLoad", {15'h0, pcLoad}, 16'h0001);
        check("startPc", startPc, 16'h0100);
        rst_n = 1'b1;
        @(negedge mclk);
        check("pcLoad", {15'h0, pcLoad}, 16'h0000);
        check("bankSel", {15'h0, bankSel}, 16'h0000);
        check("pages", {8'h00, dstPage, srcPage}, 16'h0000);
        rd(rfm_pkg::MODE_REG, 8'hdf, 8'h00, 1'b0);
        rd(rfm_pkg::MODE_REG, 8'hd6, 8'hc0, 1'b0);
        rd(rfm_pkg::MODE_REG, 8'hd7, 8'hc8, 1'b0);
        $display("test reset done");
        foreach (fa[i]) begin
            u_cpu.fetch(fa[i], h, f, v);
            check("pgmHit", {15'h0, h}, {15'h0, fa[i] <= 16'h7fff});
            check("pgmFault", {15'h0, f}, {15'h0, fa[i] > 16'h7fff});
            check("pgmVector", {15'h0, v}, {15'h0, fa[i] <= 16'h00ff});
        end
        $display("test program decode done");
        wr(rfm_pkg::MODE_REG, 8'h10, 8'ha0);
        wr(rfm_pkg::MODE_REG, 8'hdf, 8'h11);
        wr(rfm_pkg::MODE_REG, 8'h10, 8'hb1);
        rd(rfm_pkg::MODE_REG, 8'h10, 8'hb1, 1'b0);
        wr(rfm_pkg::MODE_REG, 8'hdf, 8'h22);
        wr(rfm_pkg::MODE_IND, 8'hff, 8'hc2);
        rd(rfm_pkg::MODE_IDX, 8'hff, 8'hc2, 1'b0);
        wr(rfm_pkg::MODE_REG, 8'hdf, 8'h20);
        rd(rfm_pkg::MODE_REG, 8'h10, 8'ha0, 1'b0);
        wr(rfm_pkg::MODE_REG, 8'hdf, 8'h03);
        check("pageCodeBad", {15'h0, pageCodeBad}, 16'h0001);
        rd(rfm_pkg::MODE_REG, 8'h10, 8'h00, 1'b0);
        wr(rfm_pkg::MODE_REG, 8'hdf, 8'h00);
        $display("test pages done");
        wr(rfm_pkg::MODE_REG, 8'he0, 8'h55);
        u_cpu.bank(1'b1);
        check("bankSel", {15'h0, bankSel}, 16'h0001);
        wr(rfm_pkg::MODE_REG, 8'he0, 8'h66);
        rd(rfm_pkg::MODE_REG, 8'he0, 8'h66, 1'b0);
        u_cpu.bank(1'b0);
        rd(rfm_pkg::MODE_REG, 8'he0, 8'h55, 1'b0);
        $display("test banks done");
        wr(rfm_pkg::MODE_IND, 8'hc0, 8'h77);
        rd(rfm_pkg::MODE_REG, 8'hc0, 8'h00, 1'b1);
        rd(rfm_pkg::MODE_IND, 8'hc0, 8'h77, 1'b0);
        wr(rfm_pkg::MODE_WORK, 8'h09, 8'h3c);
        rd(rfm_pkg::MODE_WORK, 8'h09, 8'h3c, 1'b0);
        rd(rfm_pkg::MODE_IND, 8'hc0, 8'h77, 1'b0);
        wr(rfm_pkg::MODE_REG, 8'hd6, 8'h70);
        wr(rfm_pkg::MODE_WORK, 8'h02, 8'h99);
        rd(rfm_pkg::MODE_REG, 8'h72, 8'h99, 1'b0);
        // A 4-bit field cannot reach D0 by itself: move the low base there
        wr(rfm_pkg::MODE_REG, 8'hd6, 8'hd0);
        rd(rfm_pkg::MODE_WORK, 8'h00, 8'h00, 1'b1);
        wr(rfm_pkg::MODE_REG, 8'hd0, 8'h5a);
        rd(rfm_pkg::MODE_REG, 8'hd0, 8'h00, 1'b0);
        $display("test modes done");
        u_cpu.bank(1'b1);
        wr(rfm_pkg::MODE_REG, 8'hdf, 8'h11);
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        check("pcLoad", {15'h0, pcLoad}, 16'h0001);
        rst_n = 1'b1;
        @(negedge mclk);
        check("pcLoad", {15'h0, pcLoad}, 16'h0000);
        check("bankSel", {15'h0, bankSel}, 16'h0000);
        check("pages", {8'h00, dstPage, srcPage}, 16'h0000);
        rd(rfm_pkg::MODE_REG, 8'hd6, 8'hc0, 1'b0);
        $display("test second reset done");
        wrap_up();
    end
endmodule : tb_top

bind rfm_addr_map rfm_addr_map_asserts #(.VARIANT(VARIANT)) u_asserts (.mclk, .rst_n,
    .pgmAddr, .pgmFetch, .pgmHit, .pgmFault, .pgmVector, .startPc, .pcLoad, .regAddr,
    .regMode, .regRd, .regWr, .regWrData, .regRdData, .regRefused, .selectLowerBankInstr,
    .selectUpperBankInstr, .bankSel, .dstPage, .srcPage, .pageCodeBad);
